// ==== hw/fsg_frame_sync_gen.sv ====
// Purpose: Camera sync waveform generator with an AXI4-Lite register port
// Assumes: Reference and general inputs are synchronous to clk
// Notes: Eight-bit registers in the low byte of each aligned word
`timescale 1ns/1ns
`include "fsg_regs.svh"
`default_nettype none

module fsg_frame_sync_gen #(
   parameter int ADDR_W = 8,
   parameter int GPIO_N = 7
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // AXI4-Lite write address
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Timing references and external sync inputs
   input wire logic frame_clk_port0,
   input wire logic frame_clk_port1,
   input wire logic [GPIO_N-1:0] gpio_in,
   // Generated sync toward remote serializers
   output logic camera_sync_pulse
);

   // Register storage
   logic [3:0] sync_source_select_q;
   logic sync_initial_level_q;
   logic sync_waveform_style_q;
   logic continuous_sync_enable_q;
   logic one_shot_pulse_request_q;
   logic [7:0] high_upper_q;
   logic [7:0] high_lower_q;
   logic [7:0] low_upper_q;
   logic [7:0] low_lower_q;
   localparam logic [7:0] CTL_RST = `FSG_RST_CONTROL; // Control reset image, sliced per field

   // Bus slave state
   logic aw_full_q;
   logic w_full_q;
   logic [5:0] aw_idx_q;
   logic [7:0] wdata_q;
   logic wstrb0_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [1:0] rresp_q;
   logic [31:0] rdata_q;
   logic wr_fire;
   logic [5:0] ar_idx;
   logic [7:0] rd_byte;
   logic rd_hit;
   logic wr_hit;

   // Generator state
   fsg_pkg::fsg_state_e state_q;
   fsg_pkg::fsg_state_e state_d;
   fsg_pkg::fsg_dur_t cnt_q;
   fsg_pkg::fsg_dur_t cnt_d;
   fsg_pkg::fsg_dur_t high_dur;
   fsg_pkg::fsg_dur_t low_dur;
   fsg_pkg::fsg_dur_t cur_dur;
   logic level_q;
   logic level_d;
   logic sync_q;
   logic ref_tick;
   logic ext_mode;
   logic ext_level;
   logic internal_src;

   // Reference and external source selection
   fsg_ref_select #(
      .GPIO_N(GPIO_N),
      .FIXED_DIV(`FSG_FIXED_REF_DIV)
   ) u_ref_select (
      .clk(clk),
      .rstn(rstn),
      .src_sel(sync_source_select_q),
      .frame_clk({frame_clk_port1, frame_clk_port0}),
      .gpio_in(gpio_in),
      .ref_tick(ref_tick),
      .ext_mode(ext_mode),
      .ext_level(ext_level)
   );

   // Internal sources: port frame clocks and the fixed reference
   assign internal_src = (sync_source_select_q == `FSG_SRC_PORT0) ||
                         (sync_source_select_q == `FSG_SRC_PORT1) ||
                         (sync_source_select_q[3:2] == `FSG_SRC_FIXED_TOP);

   // Bus handshakes: one write and one read at a time
   assign s_axi_awready = !aw_full_q && !bvalid_q;
   assign s_axi_wready = !w_full_q && !bvalid_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rresp = rresp_q;
   assign s_axi_rdata = rdata_q;
   assign wr_fire = aw_full_q && w_full_q && !bvalid_q;

   // Write address and data capture, in either order
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         aw_idx_q <= 6'h00;
         wdata_q <= 8'h00;
         wstrb0_q <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_q <= 1'b1;
            aw_idx_q <= s_axi_awaddr[7:2];
         end else if (wr_fire) begin
            aw_full_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_q <= 1'b1;
            wdata_q <= s_axi_wdata[7:0];
            wstrb0_q <= s_axi_wstrb[0];
         end else if (wr_fire) begin
            w_full_q <= 1'b0;
         end
      end
   end

   // Mapped write targets
   always_comb begin
      unique case (aw_idx_q)
         `FSG_IDX_RESERVED_A, `FSG_IDX_CONTROL, `FSG_IDX_HIGH_UPPER,
         `FSG_IDX_HIGH_LOWER, `FSG_IDX_LOW_UPPER, `FSG_IDX_LOW_LOWER,
         `FSG_IDX_STATUS: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   // Write response
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bvalid_q <= 1'b0;
         bresp_q <= `FSG_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_hit ? `FSG_RESP_OKAY : `FSG_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // Control register fields
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sync_source_select_q <= CTL_RST[`FSG_CTL_SRC_MSB:`FSG_CTL_SRC_LSB];
         sync_initial_level_q <= CTL_RST[`FSG_CTL_INIT_BIT];
         sync_waveform_style_q <= CTL_RST[`FSG_CTL_STYLE_BIT];
         continuous_sync_enable_q <= CTL_RST[`FSG_CTL_ENABLE_BIT];
         one_shot_pulse_request_q <= 1'b0;
      end else begin
         one_shot_pulse_request_q <= 1'b0;
         if (wr_fire && wstrb0_q && aw_idx_q == `FSG_IDX_CONTROL) begin
            sync_source_select_q <= wdata_q[`FSG_CTL_SRC_MSB:`FSG_CTL_SRC_LSB];
            sync_initial_level_q <= wdata_q[`FSG_CTL_INIT_BIT];
            sync_waveform_style_q <= wdata_q[`FSG_CTL_STYLE_BIT];
            continuous_sync_enable_q <= wdata_q[`FSG_CTL_ENABLE_BIT];
            one_shot_pulse_request_q <= wdata_q[`FSG_CTL_ONE_SHOT_BIT];
         end
      end
   end

   // Duration registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         high_upper_q <= `FSG_RST_HIGH_UPPER;
         high_lower_q <= `FSG_RST_HIGH_LOWER;
         low_upper_q <= `FSG_RST_LOW_UPPER;
         low_lower_q <= `FSG_RST_LOW_LOWER;
      end else if (wr_fire && wstrb0_q) begin
         if (aw_idx_q == `FSG_IDX_HIGH_UPPER) begin
            high_upper_q <= wdata_q;
         end
         if (aw_idx_q == `FSG_IDX_HIGH_LOWER) begin
            high_lower_q <= wdata_q;
         end
         if (aw_idx_q == `FSG_IDX_LOW_UPPER) begin
            low_upper_q <= wdata_q;
         end
         if (aw_idx_q == `FSG_IDX_LOW_LOWER) begin
            low_lower_q <= wdata_q;
         end
      end
   end

   // Read data mux; one-shot bit always reads zero
   assign ar_idx = s_axi_araddr[7:2];
   always_comb begin
      rd_hit = 1'b1;
      rd_byte = 8'h00;
      unique case (ar_idx)
         `FSG_IDX_RESERVED_A: rd_byte = 8'h00;
         `FSG_IDX_CONTROL: rd_byte = {sync_source_select_q, 1'b0, sync_initial_level_q,
                                      sync_waveform_style_q, continuous_sync_enable_q};
         `FSG_IDX_HIGH_UPPER: rd_byte = high_upper_q;
         `FSG_IDX_HIGH_LOWER: rd_byte = high_lower_q;
         `FSG_IDX_LOW_UPPER: rd_byte = low_upper_q;
         `FSG_IDX_LOW_LOWER: rd_byte = low_lower_q;
         `FSG_IDX_STATUS: begin
            rd_byte[`FSG_STS_LEVEL_BIT] = sync_q;
            rd_byte[`FSG_STS_RUNNING_BIT] = (state_q == fsg_pkg::FSG_CONT);
            rd_byte[`FSG_STS_SHOT_BIT] = (state_q == fsg_pkg::FSG_SHOT);
            rd_byte[`FSG_STS_EXTERNAL_BIT] = ext_mode;
         end
         default: rd_hit = 1'b0;
      endcase
   end

   // Read response
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rvalid_q <= 1'b0;
         rresp_q <= `FSG_RESP_OKAY;
         rdata_q <= 32'h0000_0000;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_q <= 1'b1;
         rresp_q <= rd_hit ? `FSG_RESP_OKAY : `FSG_RESP_SLVERR;
         rdata_q <= {24'h00_0000, rd_byte};
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // Period selection for the current level
   always_comb begin
      if (sync_waveform_style_q) begin
         high_dur = {high_lower_q, low_upper_q, low_lower_q};
         low_dur = {high_lower_q, low_upper_q, low_lower_q};
      end else begin
         high_dur = {8'h00, high_upper_q, high_lower_q};
         low_dur = {8'h00, low_upper_q, low_lower_q};
      end
      cur_dur = level_q ? high_dur : low_dur;
   end

   // Generator next state
   always_comb begin
      state_d = state_q;
      level_d = level_q;
      cnt_d = cnt_q;
      unique case (state_q)
         fsg_pkg::FSG_IDLE: begin
            level_d = sync_initial_level_q;
            cnt_d = 24'h00_0000;
            if (continuous_sync_enable_q && internal_src) begin
               state_d = fsg_pkg::FSG_CONT;
            end else if (one_shot_pulse_request_q && internal_src) begin
               state_d = fsg_pkg::FSG_SHOT;
               level_d = !sync_initial_level_q;
            end
         end
         fsg_pkg::FSG_CONT: begin
            if (!continuous_sync_enable_q || !internal_src) begin
               state_d = fsg_pkg::FSG_IDLE;
               level_d = sync_initial_level_q;
               cnt_d = 24'h00_0000;
            end else if (ref_tick) begin
               if (cnt_q >= cur_dur) begin
                  level_d = !level_q;
                  cnt_d = 24'h00_0000;
               end else begin
                  cnt_d = cnt_q + 24'h00_0001;
               end
            end
         end
         fsg_pkg::FSG_SHOT: begin
            if (!internal_src) begin
               state_d = fsg_pkg::FSG_IDLE;
               level_d = sync_initial_level_q;
               cnt_d = 24'h00_0000;
            end else if (ref_tick) begin
               if (cnt_q >= cur_dur) begin
                  state_d = fsg_pkg::FSG_IDLE;
                  level_d = sync_initial_level_q;
                  cnt_d = 24'h00_0000;
               end else begin
                  cnt_d = cnt_q + 24'h00_0001;
               end
            end
         end
         default: begin
            state_d = fsg_pkg::FSG_IDLE;
            level_d = sync_initial_level_q;
            cnt_d = 24'h00_0000;
         end
      endcase
   end

   // Generator state registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= fsg_pkg::FSG_IDLE;
         level_q <= 1'b0;
         cnt_q <= 24'h00_0000;
      end else begin
         state_q <= state_d;
         level_q <= level_d;
         cnt_q <= cnt_d;
      end
   end

   // Output: pass-through in external modes, generated level otherwise
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sync_q <= 1'b0;
      end else if (ext_mode) begin
         sync_q <= ext_level;
      end else begin
         sync_q <= level_q;
      end
   end

   assign camera_sync_pulse = sync_q;

endmodule

`default_nettype wire

// ==== hw/fsg_regs.svh ====
// Purpose: Register indices, field positions, reset values and timing for the sync generator
// Assumes: Byte address of a register is four times its index
// Notes: Registers are eight bits wide and sit in the low byte of each word
`ifndef FSG_REGS_SVH
`define FSG_REGS_SVH

// Register indices
`define FSG_IDX_RESERVED_A 6'h17
`define FSG_IDX_CONTROL 6'h18
`define FSG_IDX_HIGH_UPPER 6'h19
`define FSG_IDX_HIGH_LOWER 6'h1A
`define FSG_IDX_LOW_UPPER 6'h1B
`define FSG_IDX_LOW_LOWER 6'h1C
`define FSG_IDX_STATUS 6'h3F

// Control register field positions
`define FSG_CTL_SRC_MSB 7
`define FSG_CTL_SRC_LSB 4
`define FSG_CTL_ONE_SHOT_BIT 3
`define FSG_CTL_INIT_BIT 2
`define FSG_CTL_STYLE_BIT 1
`define FSG_CTL_ENABLE_BIT 0

// Status register field positions
`define FSG_STS_LEVEL_BIT 0
`define FSG_STS_RUNNING_BIT 1
`define FSG_STS_SHOT_BIT 2
`define FSG_STS_EXTERNAL_BIT 3

// Reset values
`define FSG_RST_CONTROL 8'h00
`define FSG_RST_HIGH_UPPER 8'h00
`define FSG_RST_HIGH_LOWER 8'h00
`define FSG_RST_LOW_UPPER 8'h00
`define FSG_RST_LOW_LOWER 8'h00

// Source select codes
`define FSG_SRC_PORT0 4'h0
`define FSG_SRC_PORT1 4'h1
`define FSG_SRC_FIXED_TOP 2'h1
`define FSG_SRC_RESERVED_EXT 4'hF

// Timing: system clock and fixed reference
`define FSG_SYS_CLK_HZ 125000000
`define FSG_FIXED_REF_HZ 25000000
`define FSG_FIXED_REF_DIV (`FSG_SYS_CLK_HZ / `FSG_FIXED_REF_HZ)

// AXI responses
`define FSG_RESP_OKAY 2'h0
`define FSG_RESP_SLVERR 2'h2

`endif

// ==== hw/fsg_pkg.sv ====
// Purpose: Types shared by the sync generator files
// Assumes: Nothing beyond the register header
// Notes: State codes are one-hot
package fsg_pkg;

   // Generator states
   typedef enum logic [2:0] {
      FSG_IDLE = 3'b001,
      FSG_CONT = 3'b010,
      FSG_SHOT = 3'b100
   } fsg_state_e;

   // Duration width covers the widest (50/50) setting
   typedef logic [23:0] fsg_dur_t;

endpackage

// ==== hw/fsg_ref_select.sv ====
// Purpose: Pick the timing reference tick and the external sync level
// Assumes: Frame clocks and general inputs are synchronous to clk
// Notes: One tick per rising edge of the chosen reference
`timescale 1ns/1ns
`include "fsg_regs.svh"
`default_nettype none

module fsg_ref_select #(
   parameter int GPIO_N = 7,
   parameter int FIXED_DIV = `FSG_FIXED_REF_DIV
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Selection
   input wire logic [3:0] src_sel,
   // Reference and external inputs
   input wire logic [1:0] frame_clk,
   input wire logic [GPIO_N-1:0] gpio_in,
   // Results
   output logic ref_tick,
   output logic ext_mode,
   output logic ext_level
);

   logic [1:0] frame_prev_q;
   logic [1:0] frame_rise;
   logic [2:0] div_q;
   logic div_tick;
   logic tick_d;

   // Rising edge of each port frame clock
   for (genvar p = 0; p < 2; p++) begin : g_port
      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn) begin
            frame_prev_q[p] <= 1'b0;
         end else begin
            frame_prev_q[p] <= frame_clk[p];
         end
      end
      assign frame_rise[p] = frame_clk[p] & ~frame_prev_q[p];
   end

   // Fixed reference divider from the system clock
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         div_q <= 3'h0;
      end else if (div_tick) begin
         div_q <= 3'h0;
      end else begin
         div_q <= div_q + 3'h1;
      end
   end
   assign div_tick = (div_q == 3'(FIXED_DIV - 1));

   // Tick source decode
   always_comb begin
      tick_d = 1'b0;
      if (src_sel == `FSG_SRC_PORT0) begin
         tick_d = frame_rise[0];
      end else if (src_sel == `FSG_SRC_PORT1) begin
         tick_d = frame_rise[1];
      end else if (src_sel[3:2] == `FSG_SRC_FIXED_TOP) begin
         tick_d = div_tick;
      end
   end

   // Registered tick and external level
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ref_tick <= 1'b0;
         ext_level <= 1'b0;
      end else begin
         ref_tick <= tick_d;
         if (src_sel[2:0] < 3'(GPIO_N)) begin
            ext_level <= gpio_in[src_sel[2:0]];
         end else begin
            ext_level <= 1'b0;
         end
      end
   end

   assign ext_mode = src_sel[3] && (src_sel != `FSG_SRC_RESERVED_EXT);

endmodule

`default_nettype wire

// ==== sim/fsg_checker.sv ====
// Purpose: Bus and sync output assertions for the sync generator
// Assumes: Bound to the top module and sees only its ports
// Notes: Shadows the control register from completed writes
`timescale 1ns/1ns
`include "fsg_regs.svh"
`default_nettype none
module fsg_checker #(
   parameter int ADDR_W = 8,
   parameter int GPIO_N = 7
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Write channels
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // Read channels
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Sync inputs and output
   input wire logic [GPIO_N-1:0] gpio_in,
   input wire logic camera_sync_pulse
);
   logic [5:0] aw_idx_q, ar_idx_q;
   logic [7:0] wd_q, ctl_q;
   logic [3:0] age_q;
   logic [GPIO_N-1:0] g1_q, g2_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // Capture addresses and write data at their handshakes
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         aw_idx_q <= 6'h00;
         ar_idx_q <= 6'h00;
         wd_q <= 8'h00;
      end else begin
         if (s_axi_awvalid && s_axi_awready) aw_idx_q <= s_axi_awaddr[7:2];
         if (s_axi_arvalid && s_axi_arready) ar_idx_q <= s_axi_araddr[7:2];
         if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata[7:0];
      end
   end
   // Control shadow and cycles since its last write
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctl_q <= 8'h00;
         age_q <= 4'h0;
      end else if (s_axi_bvalid && s_axi_bready && aw_idx_q == `FSG_IDX_CONTROL) begin
         ctl_q <= wd_q & 8'hF7;
         age_q <= 4'h0;
      end else if (age_q != 4'hF) begin
         age_q <= age_q + 4'h1;
      end
   end
   // General inputs two cycles back
   always_ff @(posedge clk) begin
      g1_q <= gpio_in;
      g2_q <= g1_q;
   end
   write_answer_a:
      assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         |-> ##2 s_axi_bvalid) else $error("write response late");
   read_answer_a:
      assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   read_hold_a:
      assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   read_block_a:
      assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
   read_resp_a:
      assert property (s_axi_rvalid |-> s_axi_rresp ==
         ((ar_idx_q inside {[6'h17:6'h1C], 6'h3F}) ? 2'h0 : 2'h2)) else $error("bad read code");
   byte_regs_a:
      assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper bits set");
   reserved_zero_a:
      assert property (s_axi_rvalid && ar_idx_q == 6'h17 |-> s_axi_rdata == 32'h0)
      else $error("reserved not zero");
   shot_reads_zero_a:
      assert property (s_axi_rvalid && ar_idx_q == `FSG_IDX_CONTROL |-> !s_axi_rdata[3])
      else $error("one-shot bit read as one");
   gpio_follow_a:
      assert property (ctl_q[7] && ctl_q[7:4] != 4'hF && age_q > 4'h2
         |-> camera_sync_pulse == g2_q[ctl_q[6:4]]) else $error("sync not following input");
   fixed_tick_a:
      assert property (ctl_q[7:6] == 2'b01 && age_q > 4'h3 && $changed(camera_sync_pulse)
         |=> $stable(camera_sync_pulse) [*4]) else $error("sync off fixed tick");
endmodule
bind fsg_frame_sync_gen fsg_checker #(.ADDR_W(ADDR_W), .GPIO_N(GPIO_N)) u_chk (
   .clk(clk), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .gpio_in(gpio_in), .camera_sync_pulse(camera_sync_pulse));
`default_nettype wire

// ==== sim/fsg_serializer_model.sv ====
// Purpose: Far side: back-channel frame clocks out, sync pulses counted in
// Assumes: Frame clocks run free, synchronous to clk
// Notes: Period of each frame clock in clk cycles is a parameter
`timescale 1ns/1ns
`default_nettype none
module fsg_serializer_model #(
   parameter int P0 = 4,
   parameter int P1 = 6
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Frame clocks toward the hub
   output logic frame_clk_port0,
   output logic frame_clk_port1,
   // Sync received from the hub
   input wire logic camera_sync_pulse,
   output int sync_rises
);
   int c0, c1;
   logic last_q;
   // Frame clock counters
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         c0 <= 0;
         c1 <= 0;
      end else begin
         c0 <= (c0 == P0 - 1) ? 0 : c0 + 1;
         c1 <= (c1 == P1 - 1) ? 0 : c1 + 1;
      end
   end
   // High for the first half of each period
   assign frame_clk_port0 = (c0 < P0 / 2);
   assign frame_clk_port1 = (c1 < P1 / 2);
   // Count rising edges of the received sync
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         last_q <= 1'b0;
         sync_rises <= 0;
      end else begin
         last_q <= camera_sync_pulse;
         if (camera_sync_pulse && !last_q) sync_rises <= sync_rises + 1;
      end
   end
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
// Purpose: Register and waveform tests for the sync generator
// Assumes: Register byte address is four times the index
// Notes: Waveform widths are counted in clk cycles
`timescale 1ns/1ns
`include "fsg_regs.svh"
`default_nettype none
module tb_top;
   localparam int P0 = 4;
   localparam int P1 = 6;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic [6:0] gpio = 7'h00;
   logic awready, wready, bvalid, arready, rvalid, sync, fclk0, fclk1;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   int n_errors = 0;
   int checked = 0;
   int cyc = 0;
   int rises, w, pre;
   // 125 MHz clock
   always #4 clk = ~clk;
   fsg_frame_sync_gen u_dut (.clk(clk), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .frame_clk_port0(fclk0), .frame_clk_port1(fclk1), .gpio_in(gpio),
      .camera_sync_pulse(sync));
   fsg_serializer_model #(.P0(P0), .P1(P1)) u_far (.clk(clk), .rstn(rstn),
      .frame_clk_port0(fclk0), .frame_clk_port1(fclk1), .camera_sync_pulse(sync),
      .sync_rises(rises));
   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Bus write, address and data offered together
   task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er);
      int n;
      @(posedge clk);
      n = 0;
      awaddr <= {idx, 2'b00};
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid && n < 50);
      bready <= 1'b0;
      if (n >= 50) n_errors++;
      chk(32'(bresp), 32'(er));
   endtask
   // Bus read, ready held from the request until data is taken
   task automatic rd(input logic [5:0] idx, input logic [31:0] exp, input logic [1:0] er);
      int n;
      @(posedge clk);
      n = 0;
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (arready) arvalid <= 1'b0;
      end while (!rvalid && n < 50);
      rready <= 1'b0;
      if (n >= 50) n_errors++;
      chk(rdata, exp);
      chk(32'(rresp), 32'(er));
   endtask
   // Width in cycles of the next whole segment at level lvl
   task automatic seg(input logic lvl, output int wd);
      int n;
      n = 0;
      wd = 0;
      while (sync === lvl && n < 400) begin
         @(posedge clk);
         n++;
      end
      while (sync !== lvl && n < 400) begin
         @(posedge clk);
         n++;
      end
      while (sync === lvl && n < 400) begin
         @(posedge clk);
         n++;
         wd++;
      end
   endtask
   // Verdict and end of run
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Cycle ceiling against hangs
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors = n_errors + 1;
         close_out();
      end
   end
   // Test sequence
   initial begin
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      for (int i = 23; i <= 28; i++) rd(6'(i), 32'h0, 2'h0);
      for (int i = 25; i <= 28; i++) wr(6'(i), 8'(8'hA0 + i), 2'h0);
      for (int i = 25; i <= 28; i++) rd(6'(i), 32'(8'hA0 + i), 2'h0);
      wr(6'h17, 8'hFF, 2'h0);
      rd(6'h17, 32'h0, 2'h0);
      wr(6'h20, 8'h01, 2'h2);
      rd(6'h20, 32'h0, 2'h2);
      $display("register test done");
      wr(`FSG_IDX_HIGH_UPPER, 8'h00, 2'h0);
      wr(`FSG_IDX_HIGH_LOWER, 8'h02, 2'h0);
      pre = rises;
      wr(`FSG_IDX_CONTROL, 8'h48, 2'h0);
      seg(1'b1, w);
      chk((w + 4) / 5, 3);
      repeat (60) @(posedge clk);
      chk(rises - pre, 1);
      rd(`FSG_IDX_CONTROL, 32'h40, 2'h0);
      $display("one-shot test done");
      wr(`FSG_IDX_HIGH_LOWER, 8'h01, 2'h0);
      wr(`FSG_IDX_LOW_UPPER, 8'h00, 2'h0);
      wr(`FSG_IDX_LOW_LOWER, 8'h02, 2'h0);
      for (int p = 0; p < 2; p++) begin
         wr(`FSG_IDX_CONTROL, 8'(8'h01 + 16 * p), 2'h0);
         seg(1'b1, w);
         chk(w, 2 * (p ? P1 : P0));
         seg(1'b0, w);
         chk(w, 3 * (p ? P1 : P0));
         wr(`FSG_IDX_CONTROL, 8'h00, 2'h0);
      end
      pre = rises;
      repeat (60) @(posedge clk);
      chk(rises - pre, 0);
      chk(32'(sync), 32'h0);
      $display("frame clock test done");
      wr(`FSG_IDX_HIGH_UPPER, 8'hFF, 2'h0);
      wr(`FSG_IDX_HIGH_LOWER, 8'h00, 2'h0);
      wr(`FSG_IDX_LOW_LOWER, 8'h01, 2'h0);
      for (int s = 4; s < 8; s++) begin
         wr(`FSG_IDX_CONTROL, 8'(16 * s + 4), 2'h0);
         repeat (4) @(posedge clk);
         chk(32'(sync), 32'h1);
         wr(`FSG_IDX_CONTROL, 8'(16 * s + 7), 2'h0);
         seg(1'b1, w);
         chk(w, 10);
         seg(1'b0, w);
         chk(w, 10);
         wr(`FSG_IDX_CONTROL, 8'h00, 2'h0);
      end
      $display("fixed reference test done");
      for (int c = 0; c < 7; c++) begin
         wr(`FSG_IDX_CONTROL, 8'(16 * (8 + c)), 2'h0);
         gpio <= 7'(1 << c);
         repeat (4) @(posedge clk);
         chk(32'(sync), 32'h1);
         gpio <= ~7'(1 << c);
         repeat (4) @(posedge clk);
         chk(32'(sync), 32'h0);
         rd(`FSG_IDX_STATUS, 32'h08, 2'h0);
      end
      $display("external source test done");
      close_out();
   end
endmodule
`default_nettype wire
